// file: cpu_core_pkg.sv
/*
  shared constants, operation encodings and carrier structs for the cpu register file core.
  assumes an external decoder turns each fetched instruction word into an op_t.
*/
package cpu_core_pkg;
  // ==========================================================================
  // sizes and map
  localparam int          REG_COUNT  = 32;
  localparam int          PTR_BASE   = 26;
  localparam logic [15:0] IO_BASE    = 16'h0020;
  localparam logic [15:0] IO_TOP     = 16'h005f;
  localparam logic [5:0]  SP_IO      = 6'h3d;
  localparam logic [5:0]  FLAG_IO    = 6'h3f;
  localparam logic [7:0]  SP_RESET   = 8'h00;
  localparam logic [7:0]  FLAG_RESET = 8'h00;
  localparam int          PC_WIDTH   = 10;
  localparam int          IRQ_COUNT  = 11;
  // ==========================================================================
  // flag register bit positions
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_N = 2;
  localparam int FL_V = 3;
  localparam int FL_S = 4;
  localparam int FL_H = 5;
  localparam int FL_T = 6;
  localparam int FL_I = 7;
  // ==========================================================================
  // encodings
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC, ALU_AND, ALU_OR, ALU_EOR, ALU_MOV,
    ALU_COM, ALU_NEG, ALU_INC, ALU_DEC, ALU_LSR, ALU_SWAP, ALU_BSET, ALU_BCLR
  } alu_fn_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_ALU_RR, OP_ALU_RI, OP_ALU_R, OP_LD_PTR, OP_ST_PTR, OP_LD_DIR, OP_ST_DIR,
    OP_IN, OP_OUT, OP_PUSH, OP_POP, OP_CALL, OP_RET, OP_RETURN_FROM_IRQ_OP, OP_JMP
  } op_kind_t;

  typedef enum logic [1:0] {PM_PLAIN, PM_POSTINC, PM_PREDEC, PM_DISP} ptr_mode_t;

  typedef enum logic [1:0] {ST_EXEC = 2'b01, ST_LOAD = 2'b10} core_state_t;

  typedef struct packed {
    op_kind_t    kind;
    alu_fn_t     fn;
    logic [4:0]  rd;
    logic [4:0]  rr;
    logic [7:0]  imm;
    logic [1:0]  ptrSel;
    ptr_mode_t   mode;
    logic [5:0]  disp;
    logic [15:0] target;
    logic        noWrite;
  } op_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
    logic        wide;
  } dmem_req_t;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
    logic       updFlags;
  } alu_out_t;
endpackage

// file: cpu_alu.sv
/*
  combinational byte alu: arithmetic, logical and bit functions with flag generation.
  assumes the caller registers the result and the flags.
*/
`timescale 1ns/1ps
module cpu_alu (
  input  wire logic [7:0]           a,
  input  wire logic [7:0]           b,
  input  wire cpu_core_pkg::alu_fn_t fn,
  input  wire logic [7:0]           flagsIn,
  output cpu_core_pkg::alu_out_t     out
);
  logic [8:0] sum;
  logic [7:0] res;
  logic       c;
  logic       h;
  logic       v;
  logic       n;
  logic       z;

  // ==========================================================================
  // operations
  always_comb begin
    sum = 9'h000;
    res = 8'h00;
    c   = flagsIn[cpu_core_pkg::FL_C];
    h   = flagsIn[cpu_core_pkg::FL_H];
    v   = 1'b0;
    out.updFlags = 1'b1;
    case (fn)
      cpu_core_pkg::ALU_ADD, cpu_core_pkg::ALU_ADC: begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, (fn == cpu_core_pkg::ALU_ADC) & c};
        res = sum[7:0];
        c   = sum[8];
        h   = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
        v   = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
      end
      cpu_core_pkg::ALU_SUB, cpu_core_pkg::ALU_SBC: begin
        sum = {1'b0, a} - {1'b0, b} - {8'h00, (fn == cpu_core_pkg::ALU_SBC) & c};
        res = sum[7:0];
        c   = sum[8];
        h   = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
        v   = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
      end
      cpu_core_pkg::ALU_AND: res = a & b;
      cpu_core_pkg::ALU_OR:  res = a | b;
      cpu_core_pkg::ALU_EOR: res = a ^ b;
      cpu_core_pkg::ALU_COM: begin
        res = ~a;
        c   = 1'b1;
      end
      cpu_core_pkg::ALU_NEG: begin
        res = 8'h00 - a;
        c   = |res;
        v   = (res == 8'h80);
      end
      cpu_core_pkg::ALU_INC: begin
        res = a + 8'h01;
        v   = (res == 8'h80);
      end
      cpu_core_pkg::ALU_DEC: begin
        res = a - 8'h01;
        v   = (res == 8'h7f);
      end
      cpu_core_pkg::ALU_LSR: begin
        res = {1'b0, a[7:1]};
        c   = a[0];
        v   = a[0];
      end
      // no flag effect for moves, nibble swap and bit set/clear by mask
      cpu_core_pkg::ALU_SWAP: begin
        res = {a[3:0], a[7:4]};
        out.updFlags = 1'b0;
      end
      cpu_core_pkg::ALU_BSET: begin
        res = a | b;
        out.updFlags = 1'b0;
      end
      cpu_core_pkg::ALU_BCLR: begin
        res = a & ~b;
        out.updFlags = 1'b0;
      end
      default: begin
        res = b;
        out.updFlags = 1'b0;
      end
    endcase
    n = res[7];
    // borrow chains keep zero only if every byte was zero
    z = (res == 8'h00) & ((fn != cpu_core_pkg::ALU_SBC) | flagsIn[cpu_core_pkg::FL_Z]);
    out.res   = res;
    out.flags = {flagsIn[cpu_core_pkg::FL_I], flagsIn[cpu_core_pkg::FL_T], h, n ^ v, v, n, z, c};
  end
endmodule

// file: cpu_register_file_core.sv
/*
  register file core: 32 byte registers, pointer pairs, data space decode, fetch pipeline,
  stack pointer, flag register and vectored interrupt entry.
  assumes a combinational decoder turns instrQ into opIn within the same cycle, and a data
  memory that answers a read in the cycle its read strobe is high.
*/
// Overview of operation
// - thirty-two byte registers, each reachable in one clock.
// - two operands read, computed and written back in one clock.
// - six registers pair into three 16-bit pointers.
// - pointer pairs are registers 26 to 31, still general purpose.
// - data addresses 0x00-0x1f reach the register file.
// - 64 io locations, direct or at data addresses 0x20-0x5f.
// - constant-operand ops only address registers 16 to 31.
// - register and single-register ops address all 32 registers.
// - pointer holding a register-file address reaches that register.
// - pointers support displacement, post-increment and pre-decrement.
// - next word fetched while current executes, one instruction per clock.
// - each program address holds one 16-bit instruction word.
// - one vector per interrupt; lowest vector wins.
// - calls and interrupts push return address; 8-bit stack pointer in io space.
// - alu does register, constant and single-register ops in three groups.
// - interrupt entry clears global enable; interrupt return sets it.
// - stack pointer drops one per byte push, two per address push.
`timescale 1ns/1ps
module cpu_register_file_core #(
  parameter int PC_W  = cpu_core_pkg::PC_WIDTH,
  parameter int IRQ_N = cpu_core_pkg::IRQ_COUNT
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic [15:0]           progWord,
  input  wire cpu_core_pkg::op_t     opIn,
  input  wire logic [15:0]           memRdata,
  input  wire logic [IRQ_N-1:0]      irqReq,
  output logic [PC_W-1:0]            pcQ,
  output logic [15:0]                instrQ,
  output logic                       instrValidQ,
  output cpu_core_pkg::dmem_req_t    memQ,
  output logic [7:0]                 stackTopPointerQ,
  output logic [7:0]                 flagRegisterQ,
  output logic [IRQ_N-1:0]           irqAckQ,
  output logic                       busyQ
);
  // ==========================================================================
  // elaboration checks
  if (PC_W < 4 || PC_W > 16) $error("PC_W must lie in 4..16");
  if (IRQ_N < 1 || IRQ_N >= (1 << PC_W) - 1) $error("IRQ_N does not fit the vector table");

  // ==========================================================================
  // state
  logic [7:0]                  regsQ [cpu_core_pkg::REG_COUNT];
  cpu_core_pkg::core_state_t   stateQ;
  cpu_core_pkg::op_kind_t      pendKindQ;
  logic [4:0]                  pendRdQ;

  // ==========================================================================
  // operand and address selection
  cpu_core_pkg::alu_out_t aluOut;
  logic [4:0]             rdEff;
  logic [7:0]             bOp;
  logic [4:0]             ptrLo;
  logic [15:0]            ptr;
  logic [15:0]            newPtr;
  logic [15:0]            dataAddr;
  logic [15:0]            stackAddr;
  logic                   isReg;
  logic                   isSp;
  logic                   isFlag;
  logic                   isPtrOp;
  logic                   isLoad;
  logic                   isStore;
  logic                   isStack;
  logic                   isAlu;
  logic [7:0]             intRd;

  always_comb begin
    rdEff = (opIn.kind == cpu_core_pkg::OP_ALU_RI) ? {1'b1, opIn.rd[3:0]} : opIn.rd;
    bOp   = (opIn.kind == cpu_core_pkg::OP_ALU_RR) ? regsQ[opIn.rr] : opIn.imm;
    ptrLo = 5'(cpu_core_pkg::PTR_BASE) + {2'b00, opIn.ptrSel, 1'b0};
    ptr   = {regsQ[ptrLo + 5'd1], regsQ[ptrLo]};
    case (opIn.mode)
      cpu_core_pkg::PM_PREDEC:  newPtr = ptr - 16'h0001;
      cpu_core_pkg::PM_POSTINC: newPtr = ptr + 16'h0001;
      default:                  newPtr = ptr;
    endcase
    isPtrOp = (opIn.kind == cpu_core_pkg::OP_LD_PTR) || (opIn.kind == cpu_core_pkg::OP_ST_PTR);
    if (isPtrOp && opIn.mode == cpu_core_pkg::PM_PREDEC)
      dataAddr = newPtr;
    else if (isPtrOp && opIn.mode == cpu_core_pkg::PM_DISP)
      dataAddr = ptr + {10'h000, opIn.disp};
    else if (isPtrOp)
      dataAddr = ptr;
    else if (opIn.kind == cpu_core_pkg::OP_IN || opIn.kind == cpu_core_pkg::OP_OUT)
      dataAddr = cpu_core_pkg::IO_BASE + {10'h000, opIn.disp};
    else
      dataAddr = opIn.target;
    isReg  = dataAddr < cpu_core_pkg::IO_BASE;
    isSp   = dataAddr == cpu_core_pkg::IO_BASE + {10'h000, cpu_core_pkg::SP_IO};
    isFlag = dataAddr == cpu_core_pkg::IO_BASE + {10'h000, cpu_core_pkg::FLAG_IO};
    if (isReg)
      intRd = regsQ[dataAddr[4:0]];
    else if (isSp)
      intRd = stackTopPointerQ;
    else
      intRd = flagRegisterQ;
    isStack = opIn.kind inside {cpu_core_pkg::OP_PUSH, cpu_core_pkg::OP_POP, cpu_core_pkg::OP_CALL,
                                cpu_core_pkg::OP_RET, cpu_core_pkg::OP_RETURN_FROM_IRQ_OP};
    isLoad  = opIn.kind inside {cpu_core_pkg::OP_LD_PTR, cpu_core_pkg::OP_LD_DIR, cpu_core_pkg::OP_IN,
                                cpu_core_pkg::OP_POP, cpu_core_pkg::OP_RET, cpu_core_pkg::OP_RETURN_FROM_IRQ_OP};
    isStore = opIn.kind inside {cpu_core_pkg::OP_ST_PTR, cpu_core_pkg::OP_ST_DIR, cpu_core_pkg::OP_OUT};
    isAlu   = opIn.kind inside {cpu_core_pkg::OP_ALU_RR, cpu_core_pkg::OP_ALU_RI, cpu_core_pkg::OP_ALU_R};
    if (opIn.kind == cpu_core_pkg::OP_POP || opIn.kind == cpu_core_pkg::OP_RET || opIn.kind == cpu_core_pkg::OP_RETURN_FROM_IRQ_OP)
      stackAddr = {8'h00, stackTopPointerQ + 8'h01};
    else if (opIn.kind == cpu_core_pkg::OP_CALL)
      stackAddr = {8'h00, stackTopPointerQ - 8'h01};
    else
      stackAddr = {8'h00, stackTopPointerQ};
  end

  cpu_alu u_alu (
    .a       (regsQ[rdEff]),
    .b       (bOp),
    .fn      (opIn.fn),
    .flagsIn (flagRegisterQ),
    .out     (aluOut)
  );

  // ==========================================================================
  // execution control
  logic            takeIrq;
  logic            doExec;
  logic            extLoad;
  logic            extStore;
  logic            jumpNow;
  logic [PC_W-1:0] irqVec;
  logic [IRQ_N-1:0] irqOneHot;

  always_comb begin
    irqVec    = '0;
    irqOneHot = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (irqReq[i]) begin
        irqVec    = PC_W'(i + 1);
        irqOneHot = IRQ_N'(1) << i;
      end
    end
    takeIrq  = (stateQ == cpu_core_pkg::ST_EXEC) && instrValidQ && flagRegisterQ[cpu_core_pkg::FL_I] && (|irqReq);
    doExec   = (stateQ == cpu_core_pkg::ST_EXEC) && instrValidQ && !takeIrq;
    extLoad  = doExec && isLoad && (isStack || !(isReg || isSp || isFlag));
    extStore = doExec && (isStore && !(isReg || isSp || isFlag) || opIn.kind == cpu_core_pkg::OP_PUSH
               || opIn.kind == cpu_core_pkg::OP_CALL);
    jumpNow  = doExec && (opIn.kind == cpu_core_pkg::OP_CALL || opIn.kind == cpu_core_pkg::OP_JMP);
  end

  // ==========================================================================
  // fetch pipeline and state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stateQ      <= cpu_core_pkg::ST_EXEC;
      pcQ         <= '0;
      instrQ      <= 16'h0000;
      instrValidQ <= 1'b0;
      busyQ       <= 1'b0;
      pendKindQ   <= cpu_core_pkg::OP_NOP;
      pendRdQ     <= 5'h00;
    end else if (ce) begin
      if (takeIrq) begin
        pcQ         <= irqVec;
        instrValidQ <= 1'b0;
      end else if (jumpNow) begin
        pcQ         <= opIn.target[PC_W-1:0];
        instrValidQ <= 1'b0;
      end else if (extLoad) begin
        stateQ    <= cpu_core_pkg::ST_LOAD;
        busyQ     <= 1'b1;
        pendKindQ <= opIn.kind;
        pendRdQ   <= opIn.rd;
      end else if (stateQ == cpu_core_pkg::ST_LOAD) begin
        stateQ <= cpu_core_pkg::ST_EXEC;
        busyQ  <= 1'b0;
        if (pendKindQ == cpu_core_pkg::OP_RET || pendKindQ == cpu_core_pkg::OP_RETURN_FROM_IRQ_OP) begin
          pcQ         <= memRdata[PC_W-1:0];
          instrValidQ <= 1'b0;
        end else begin
          pcQ         <= pcQ + PC_W'(1);
          instrQ      <= progWord;
          instrValidQ <= 1'b1;
        end
      end else begin
        pcQ         <= pcQ + PC_W'(1);
        instrQ      <= progWord;
        instrValidQ <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // register file writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < cpu_core_pkg::REG_COUNT; i++) regsQ[i] <= 8'h00;
    end else if (ce) begin
      if (doExec && isAlu && !opIn.noWrite)
        regsQ[rdEff] <= aluOut.res;
      if (doExec && isLoad && !extLoad)
        regsQ[opIn.rd] <= intRd;
      if (doExec && isStore && isReg)
        regsQ[dataAddr[4:0]] <= regsQ[opIn.rd];
      if (doExec && isPtrOp && (opIn.mode == cpu_core_pkg::PM_POSTINC || opIn.mode == cpu_core_pkg::PM_PREDEC)) begin
        regsQ[ptrLo]        <= newPtr[7:0];
        regsQ[ptrLo + 5'd1] <= newPtr[15:8];
      end
      if (stateQ == cpu_core_pkg::ST_LOAD && pendKindQ != cpu_core_pkg::OP_RET && pendKindQ != cpu_core_pkg::OP_RETURN_FROM_IRQ_OP)
        regsQ[pendRdQ] <= memRdata[7:0];
    end
  end

  // ==========================================================================
  // stack pointer and flag register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stackTopPointerQ <= cpu_core_pkg::SP_RESET;
      flagRegisterQ    <= cpu_core_pkg::FLAG_RESET;
    end else if (ce) begin
      if (takeIrq) begin
        stackTopPointerQ                <= stackTopPointerQ - 8'h02;
        flagRegisterQ[cpu_core_pkg::FL_I] <= 1'b0;
      end else if (doExec) begin
        case (opIn.kind)
          cpu_core_pkg::OP_PUSH: stackTopPointerQ <= stackTopPointerQ - 8'h01;
          cpu_core_pkg::OP_POP:  stackTopPointerQ <= stackTopPointerQ + 8'h01;
          cpu_core_pkg::OP_CALL: stackTopPointerQ <= stackTopPointerQ - 8'h02;
          cpu_core_pkg::OP_RET, cpu_core_pkg::OP_RETURN_FROM_IRQ_OP: stackTopPointerQ <= stackTopPointerQ + 8'h02;
          default: begin
            if (isStore && isSp)
              stackTopPointerQ <= regsQ[opIn.rd];
            if (isStore && isFlag)
              flagRegisterQ <= regsQ[opIn.rd];
            else if (isAlu && aluOut.updFlags)
              flagRegisterQ <= aluOut.flags;
          end
        endcase
      end else if (stateQ == cpu_core_pkg::ST_LOAD && pendKindQ == cpu_core_pkg::OP_RETURN_FROM_IRQ_OP) begin
        flagRegisterQ[cpu_core_pkg::FL_I] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // data memory requests and interrupt acknowledge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memQ    <= '0;
      irqAckQ <= '0;
    end else if (ce) begin
      memQ.we   <= 1'b0;
      memQ.re   <= 1'b0;
      memQ.wide <= 1'b0;
      irqAckQ   <= takeIrq ? irqOneHot : '0;
      if (takeIrq) begin
        memQ.addr  <= {8'h00, stackTopPointerQ - 8'h01};
        memQ.wdata <= 16'(pcQ - PC_W'(1));
        memQ.we    <= 1'b1;
        memQ.wide  <= 1'b1;
      end else if (extStore) begin
        memQ.addr  <= isStack ? stackAddr : dataAddr;
        memQ.wdata <= (opIn.kind == cpu_core_pkg::OP_CALL) ? 16'(pcQ) : {8'h00, regsQ[opIn.rd]};
        memQ.we    <= 1'b1;
        memQ.wide  <= opIn.kind == cpu_core_pkg::OP_CALL;
      end else if (extLoad) begin
        memQ.addr <= isStack ? stackAddr : dataAddr;
        memQ.re   <= 1'b1;
        memQ.wide <= opIn.kind == cpu_core_pkg::OP_RET || opIn.kind == cpu_core_pkg::OP_RETURN_FROM_IRQ_OP;
      end
    end
  end

  // ==========================================================================
  // checks
  a_push_dec_one: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_PUSH |=> stackTopPointerQ == $past(stackTopPointerQ) - 8'h01)
    else $error("push did not lower stack pointer by one");
  a_call_dec_two: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_CALL |=> stackTopPointerQ == $past(stackTopPointerQ) - 8'h02
    && memQ.we && memQ.wide)
    else $error("call did not push a two byte return address");
  a_irq_entry: assert property (@(posedge clk_sys) disable iff (rst)
    ce && takeIrq |=> !flagRegisterQ[cpu_core_pkg::FL_I] && !instrValidQ && $onehot(irqAckQ))
    else $error("interrupt entry left global enable set");
  a_irq_vector: assert property (@(posedge clk_sys) disable iff (rst)
    ce && takeIrq && irqReq[0] |=> pcQ == PC_W'(1) && irqAckQ[0])
    else $error("lowest vector did not win");
  a_return_from_irq_op_enable: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_RETURN_FROM_IRQ_OP |=> busyQ ##1 flagRegisterQ[cpu_core_pkg::FL_I] || !ce)
    else $error("interrupt return did not set global enable");
  a_fetch_step: assert property (@(posedge clk_sys) disable iff (rst)
    ce && stateQ == cpu_core_pkg::ST_EXEC && !takeIrq && !jumpNow && !extLoad
    |=> pcQ == $past(pcQ) + PC_W'(1) && instrValidQ && instrQ == $past(progWord))
    else $error("fetch did not advance with execution");
  a_imm_upper: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_ALU_RI && !opIn.noWrite
    |=> regsQ[{1'b1, $past(opIn.rd[3:0])}] == $past(aluOut.res))
    else $error("constant op missed the upper register half");
  a_rr_writeback: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_ALU_RR && !opIn.noWrite
    |=> regsQ[$past(opIn.rd)] == $past(aluOut.res))
    else $error("register result not written back in one cycle");
  a_ptr_postinc: assert property (@(posedge clk_sys) disable iff (rst)
    ce && doExec && opIn.kind == cpu_core_pkg::OP_ST_PTR && opIn.mode == cpu_core_pkg::PM_POSTINC
    && !isReg |=> {regsQ[$past(ptrLo) + 5'd1], regsQ[$past(ptrLo)]} == $past(ptr) + 16'h0001)
    else $error("pointer post-increment wrong");
endmodule

// file: cpu_register_file_core_tb.sv
/*
  self-checking bench for cpu_register_file_core: feeds decoded ops, judges bus, pointer and flag effects.
  assumes cpu_core_pkg and the design are compiled first; assertions live in the design files.
*/
`timescale 1ns/1ps
module cpu_register_file_core_tb;
  // ==========================================================================
  // stimulus, outputs, counters
  logic                                  clk_sys = 1'b0;
  logic                                  rst = 1'b1;
  logic                                  ce = 1'b1;
  logic [15:0]                           progWord = 16'ha5c3;
  cpu_core_pkg::op_t                     opIn = '0;
  logic [15:0]                           memRdata = 16'h0041;
  logic [cpu_core_pkg::IRQ_COUNT-1:0]    irqReq = '0;
  logic [cpu_core_pkg::PC_WIDTH-1:0]     pcQ;
  logic [15:0]                           instrQ;
  logic                                  instrValidQ;
  cpu_core_pkg::dmem_req_t               memQ;
  logic [7:0]                            stackTopPointerQ;
  logic [7:0]                            flagRegisterQ;
  logic [cpu_core_pkg::IRQ_COUNT-1:0]    irqAckQ;
  logic                                  busyQ;
  int                                    miscompares = 0;
  int                                    n_checks = 0;
  int                                    cycles = 0;
  logic [15:0]                           retPc;

  always #25 clk_sys = ~clk_sys;

  cpu_register_file_core dut (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .ce               (ce),
    .progWord         (progWord),
    .opIn             (opIn),
    .memRdata         (memRdata),
    .irqReq           (irqReq),
    .pcQ              (pcQ),
    .instrQ           (instrQ),
    .instrValidQ      (instrValidQ),
    .memQ             (memQ),
    .stackTopPointerQ (stackTopPointerQ),
    .flagRegisterQ    (flagRegisterQ),
    .irqAckQ          (irqAckQ),
    .busyQ            (busyQ)
  );

  // ==========================================================================
  // helpers
  function automatic cpu_core_pkg::op_t mk(cpu_core_pkg::op_kind_t k, cpu_core_pkg::alu_fn_t f,
                                           logic [4:0] d, logic [4:0] r, logic [7:0] i, logic [15:0] t);
    cpu_core_pkg::op_t o;
    o = '0;
    o.kind = k;
    o.fn = f;
    o.rd = d;
    o.rr = r;
    o.imm = i;
    o.target = t;
    o.disp = t[5:0];
    return o;
  endfunction

  function automatic cpu_core_pkg::op_t pst(logic [1:0] s, cpu_core_pkg::ptr_mode_t m, logic [5:0] d);
    cpu_core_pkg::op_t o;
    o = mk(cpu_core_pkg::OP_ST_PTR, cpu_core_pkg::ALU_MOV, 5'h10, 5'h10, 8'h00, {10'h000, d});
    o.ptrSel = s;
    o.mode = m;
    return o;
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic run(input cpu_core_pkg::op_t o);
    @(posedge clk_sys);
    opIn <= o;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      opIn <= '0;
    end
    #1;
  endtask

  task automatic load_const_op(input logic [4:0] r, input logic [7:0] v);
    run(mk(cpu_core_pkg::OP_ALU_RI, cpu_core_pkg::ALU_MOV, r, r, v, 16'h0000));
  endtask

  // one store op, then judge the external write it leaves on the bus
  task automatic st_bus(input cpu_core_pkg::op_t o, input logic [15:0] a, input logic [7:0] e);
    run(o);
    idle(1);
    chk("write strobe", 16'h0001, {15'h0000, memQ.we});
    chk("write address", a, memQ.addr);
    chk("write data", {8'h00, e}, {8'h00, memQ.wdata[7:0]});
  endtask

  task automatic st_reg(input logic [4:0] r, input logic [7:0] e);
    st_bus(mk(cpu_core_pkg::OP_ST_DIR, cpu_core_pkg::ALU_MOV, r, r, 8'h00, 16'h0060), 16'h0060, e);
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      finish_test();
    end
  end

  // ==========================================================================
  // scenarios
  task automatic t_fetch();
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    idle(1);
    chk("first fetch pc", 16'h0001, {6'h00, pcQ});
    chk("fetched word", 16'ha5c3, instrQ);
    idle(2);
    @(posedge clk_sys);
    ce <= 1'b0;
    idle(2);
    chk("pc held while disabled", 16'h0004, {6'h00, pcQ});
    @(posedge clk_sys);
    ce <= 1'b1;
  endtask

  task automatic t_alu();
    load_const_op(5'h00, 8'h3c);
    load_const_op(5'h01, 8'h05);
    st_reg(5'h11, 8'h05);
    st_reg(5'h01, 8'h00);
    run(mk(cpu_core_pkg::OP_ALU_RR, cpu_core_pkg::ALU_ADD, 5'h11, 5'h10, 8'h00, 16'h0000));
    run(mk(cpu_core_pkg::OP_ALU_RR, cpu_core_pkg::ALU_MOV, 5'h02, 5'h11, 8'h00, 16'h0000));
    st_reg(5'h02, 8'h41);
  endtask

  task automatic t_ptr();
    load_const_op(5'h0a, 8'h23);
    load_const_op(5'h0b, 8'h01);
    st_bus(pst(2'd0, cpu_core_pkg::PM_POSTINC, 6'h00), 16'h0123, 8'h3c);
    st_bus(pst(2'd0, cpu_core_pkg::PM_PREDEC, 6'h00), 16'h0123, 8'h3c);
    load_const_op(5'h0c, 8'h20);
    load_const_op(5'h0d, 8'h01);
    st_bus(pst(2'd1, cpu_core_pkg::PM_DISP, 6'h05), 16'h0125, 8'h3c);
    load_const_op(5'h0e, 8'h03);
    load_const_op(5'h0f, 8'h00);
    run(pst(2'd2, cpu_core_pkg::PM_PLAIN, 6'h00));
    idle(1);
    chk("no bus write for register address", 16'h0000, {15'h0000, memQ.we});
    st_reg(5'h03, 8'h3c);
  endtask

  task automatic t_stack();
    load_const_op(5'h02, 8'h80);
    run(mk(cpu_core_pkg::OP_ST_DIR, cpu_core_pkg::ALU_MOV, 5'h12, 5'h12, 8'h00, 16'h005d));
    idle(1);
    chk("stack pointer via data space", 16'h0080, {8'h00, stackTopPointerQ});
    st_bus(mk(cpu_core_pkg::OP_PUSH, cpu_core_pkg::ALU_MOV, 5'h10, 5'h10, 8'h00, 16'h0000), 16'h0080, 8'h3c);
    chk("stack pointer after push", 16'h007f, {8'h00, stackTopPointerQ});
    retPc = {6'h00, pcQ} + 16'h0001;
    run(mk(cpu_core_pkg::OP_CALL, cpu_core_pkg::ALU_MOV, 5'h00, 5'h00, 8'h00, 16'h0040));
    idle(1);
    chk("call push address", 16'h007e, memQ.addr);
    chk("call return address", retPc, memQ.wdata);
    chk("call wide write", 16'h0003, {14'h0000, memQ.we, memQ.wide});
    chk("stack pointer after call", 16'h007d, {8'h00, stackTopPointerQ});
    chk("call target", 16'h0040, {6'h00, pcQ});
    idle(2);
  endtask

  task automatic t_irq();
    load_const_op(5'h03, 8'h80);
    run(mk(cpu_core_pkg::OP_OUT, cpu_core_pkg::ALU_MOV, 5'h13, 5'h13, 8'h00, 16'h003f));
    irqReq <= 11'h006;
    idle(2);
    chk("interrupt acknowledge", 16'h0002, {5'h00, irqAckQ});
    chk("interrupt vector", 16'h0002, {6'h00, pcQ});
    chk("enable cleared on entry", 16'h0000, {15'h0000, flagRegisterQ[7]});
    chk("stack pointer after entry", 16'h007b, {8'h00, stackTopPointerQ});
    chk("entry push address", 16'h007c, memQ.addr);
    @(posedge clk_sys);
    irqReq <= '0;
    idle(2);
    run(mk(cpu_core_pkg::OP_RETURN_FROM_IRQ_OP, cpu_core_pkg::ALU_MOV, 5'h00, 5'h00, 8'h00, 16'h0000));
    idle(3);
    chk("enable set on return", 16'h0001, {15'h0000, flagRegisterQ[7]});
    chk("stack pointer after return", 16'h007d, {8'h00, stackTopPointerQ});
    @(posedge clk_sys);
    irqReq <= 11'h005;
    idle(1);
    chk("highest priority acknowledge", 16'h0001, {5'h00, irqAckQ});
    chk("highest priority vector", 16'h0001, {6'h00, pcQ});
    @(posedge clk_sys);
    irqReq <= '0;
    idle(1);
  endtask

  initial begin
    t_fetch();
    t_alu();
    t_ptr();
    t_stack();
    t_irq();
    finish_test();
  end
endmodule
